// file: logic/p8mux_top.sv
// Port 8 pin function mux with readback, behind an AHB-Lite slave.
// Assumes peripherals on core_clk; pins are asynchronous and resolved
// outside from pin_out and pin_oe.
// Function
// - Readback gives latch where direction is 1, pin level where 0.
// - Readback register is read-only; writes change nothing.
// - Pins 7 and 6 carry timer signals only with route bit set.
// - Pin 7 drives timer B on compare or PWM mode 2 output.
// - Pin 7 is timer B capture input on normal mode, io 10xx.
// - Both trigger source bits set feed pin 7 to A/D trigger.
// - Pin 6 drives timer A on compare, PWM mode 1 or 2.
// - Pin 6 is timer A capture input on normal mode, io 10xx.
// - Timer A PWM mode 1 on pin 6 suppresses timer B output.
// - Pin 5 outputs PWM wave 1 when enable B is set.
// - Pin 4 outputs PWM wave 0 when enable A is set.
// - Pins 3,1: two-wire data, else serial receive, else GPIO.
// - Pins 2,0: two-wire clock, else serial transmit, else GPIO.
// - GPIO and serial transmit on pins 0 to 3 are push-pull.
// - Two-wire data and clock only pull low, else release.
// - In GPIO function, direction 1 is output, 0 is input.
// - GPIO outputs drive the output latch value.
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`default_nettype none
`include "p8mux_defines.svh"
module p8mux_top (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Pins
   input  wire logic [7:0]  pin_in,
   output var  logic [7:0]  pin_out,
   output var  logic [7:0]  pin_oe,
   // Timer channel 0
   input  wire logic [3:0]  timer_mode_field,
   input  wire logic [3:0]  timer_a_io_ctrl,
   input  wire logic [3:0]  timer_b_io_ctrl,
   input  wire logic [2:0]  counter_clear_sel,
   input  wire logic        timer_a_signal_out,
   input  wire logic        timer_b_signal_out,
   output var  logic        timer_a_signal_in,
   output var  logic        timer_b_signal_in,
   output var  logic        timer_a_capture_en,
   output var  logic        timer_b_capture_en,
   // A/D converter
   input  wire logic        adc_trig_src_hi,
   input  wire logic        adc_trig_src_lo,
   output var  logic        adc_ext_trigger,
   output var  logic        adc_ext_trigger_en,
   // PWM converter
   input  wire logic        pwm_out_enable_a,
   input  wire logic        pwm_out_enable_b,
   input  wire logic        pwm_wave_out0,
   input  wire logic        pwm_wave_out1,
   // Serial channels
   input  wire logic        serial3_rx_enable,
   input  wire logic        serial3_tx_enable,
   input  wire logic        serial3_tx_pin,
   output var  logic        serial3_rx_pin,
   input  wire logic        serial4_rx_enable,
   input  wire logic        serial4_tx_enable,
   input  wire logic        serial4_tx_pin,
   output var  logic        serial4_rx_pin,
   // Two-wire buses; drive inputs are wanted levels, 0 pulls low
   input  wire logic        twowire0_enable,
   input  wire logic        twowire0_data_drv,
   input  wire logic        twowire0_clk_drv,
   output var  logic        twowire0_data_pin,
   output var  logic        twowire0_clk_pin,
   input  wire logic        twowire1_enable,
   input  wire logic        twowire1_data_drv,
   input  wire logic        twowire1_clk_drv,
   output var  logic        twowire1_data_pin,
   output var  logic        twowire1_clk_pin
);
   logic [7:0] pin_s;
   logic [7:0] direction_bits;
   logic [7:0] output_latch;
   logic [1:0] timer_pin_route_ctrl;
   logic [7:0] pin_level_readback;
   logic [7:0] pin_out_nxt;
   logic [7:0] pin_oe_nxt;

   function automatic logic io_is_compare(input logic [3:0] io);
      io_is_compare = !io[3] && (io[1:0] != 2'b00);
   endfunction : io_is_compare

   function automatic logic io_is_active(input logic [3:0] io);
      io_is_active = io[1:0] != 2'b00;
   endfunction : io_is_active

   function automatic logic io_is_capture(input logic [3:0] io);
      io_is_capture = io[3:2] == 2'b10;
   endfunction : io_is_capture

   function automatic p8mux_pkg::p8mux_low_fn_t low_fn(
      input logic tw_en,
      input logic ser_en
   );
      if (tw_en) begin
         low_fn = p8mux_pkg::P8MUX_FN_TWOWIRE;
      end else if (ser_en) begin
         low_fn = p8mux_pkg::P8MUX_FN_SERIAL;
      end else begin
         low_fn = p8mux_pkg::P8MUX_FN_GPIO;
      end
   endfunction : low_fn

   p8mux_sync #(
      .W (8)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (pin_in),
      .sync_out (pin_s)
   );

   p8mux_ahb_regs u_regs (
      .core_clk             (core_clk),
      .rst_n                (rst_n),
      .hsel                 (hsel),
      .haddr                (haddr),
      .htrans               (htrans),
      .hwrite               (hwrite),
      .hsize                (hsize),
      .hwdata               (hwdata),
      .hready               (hready),
      .hreadyout            (hreadyout),
      .hresp                (hresp),
      .hrdata               (hrdata),
      .readback             (pin_level_readback),
      .direction_bits       (direction_bits),
      .output_latch         (output_latch),
      .timer_pin_route_ctrl (timer_pin_route_ctrl)
   );

   // Readback mixes latch and sampled level per direction bit
   assign pin_level_readback = (direction_bits & output_latch) |
                               (~direction_bits & pin_s);

   // Timer channel 0 decode
   wire route_a = timer_pin_route_ctrl[`P8MUX_ROUTE_A_BIT];
   wire route_b = timer_pin_route_ctrl[`P8MUX_ROUTE_B_BIT];
   wire mode_nrm = timer_mode_field == `P8MUX_MODE_NORMAL;
   wire mode_pw1 = timer_mode_field == `P8MUX_MODE_PWM1;
   wire mode_pw2 = timer_mode_field == `P8MUX_MODE_PWM2;
   wire a_cmp = mode_nrm && io_is_compare(timer_a_io_ctrl);
   wire a_pwm1 = mode_pw1 && io_is_active(timer_a_io_ctrl);
   wire a_pwm2 = mode_pw2 && io_is_active(timer_a_io_ctrl) &&
                 (counter_clear_sel != `P8MUX_CCLR_A_NOPWM2);
   wire a_drive = route_a && (a_cmp || a_pwm1 || a_pwm2);
   wire a_pwm1_on_pin = route_a && a_pwm1;
   wire b_cmp = mode_nrm && io_is_compare(timer_b_io_ctrl);
   wire b_pwm2 = mode_pw2 && io_is_active(timer_b_io_ctrl) &&
                 (counter_clear_sel != `P8MUX_CCLR_B_NOPWM2);
   wire b_drive = route_b && (b_cmp || b_pwm2) &&
                  !a_pwm1_on_pin;
   wire a_cap = route_a && mode_nrm &&
                io_is_capture(timer_a_io_ctrl);
   wire b_cap = route_b && mode_nrm &&
                io_is_capture(timer_b_io_ctrl);
   wire trig_sel = adc_trig_src_hi && adc_trig_src_lo;

   // Low pin functions
   p8mux_pkg::p8mux_low_fn_t fn_ch4;
   p8mux_pkg::p8mux_low_fn_t fn_ct4;
   p8mux_pkg::p8mux_low_fn_t fn_ch3;
   p8mux_pkg::p8mux_low_fn_t fn_ct3;
   assign fn_ch4 = low_fn(twowire1_enable, serial4_rx_enable);
   assign fn_ct4 = low_fn(twowire1_enable, serial4_tx_enable);
   assign fn_ch3 = low_fn(twowire0_enable, serial3_rx_enable);
   assign fn_ct3 = low_fn(twowire0_enable, serial3_tx_enable);

   wire gpio_out7 = b_drive ? timer_b_signal_out : output_latch[7];
   wire gpio_out6 = a_drive ? timer_a_signal_out : output_latch[6];

   always_comb begin
      // GPIO default: latch drives, direction enables
      pin_out_nxt = output_latch;
      pin_oe_nxt  = direction_bits;
      pin_out_nxt[7] = gpio_out7;
      pin_oe_nxt[7]  = b_drive || direction_bits[7];
      pin_out_nxt[6] = gpio_out6;
      pin_oe_nxt[6]  = a_drive || direction_bits[6];
      if (pwm_out_enable_b) begin
         pin_out_nxt[5] = pwm_wave_out1;
         pin_oe_nxt[5]  = 1'b1;
      end
      if (pwm_out_enable_a) begin
         pin_out_nxt[4] = pwm_wave_out0;
         pin_oe_nxt[4]  = 1'b1;
      end
      // Two-wire is open drain: never drive high, enable only to pull low
      if (fn_ch4 == p8mux_pkg::P8MUX_FN_TWOWIRE) begin
         pin_out_nxt[3] = 1'b0;
         pin_oe_nxt[3]  = !twowire1_data_drv;
      end else if (fn_ch4 == p8mux_pkg::P8MUX_FN_SERIAL) begin
         pin_oe_nxt[3]  = 1'b0;
      end
      if (fn_ct4 == p8mux_pkg::P8MUX_FN_TWOWIRE) begin
         pin_out_nxt[2] = 1'b0;
         pin_oe_nxt[2]  = !twowire1_clk_drv;
      end else if (fn_ct4 == p8mux_pkg::P8MUX_FN_SERIAL) begin
         pin_out_nxt[2] = serial4_tx_pin;
         pin_oe_nxt[2]  = 1'b1;
      end
      if (fn_ch3 == p8mux_pkg::P8MUX_FN_TWOWIRE) begin
         pin_out_nxt[1] = 1'b0;
         pin_oe_nxt[1]  = !twowire0_data_drv;
      end else if (fn_ch3 == p8mux_pkg::P8MUX_FN_SERIAL) begin
         pin_oe_nxt[1]  = 1'b0;
      end
      if (fn_ct3 == p8mux_pkg::P8MUX_FN_TWOWIRE) begin
         pin_out_nxt[0] = 1'b0;
         pin_oe_nxt[0]  = !twowire0_clk_drv;
      end else if (fn_ct3 == p8mux_pkg::P8MUX_FN_SERIAL) begin
         pin_out_nxt[0] = serial3_tx_pin;
         pin_oe_nxt[0]  = 1'b1;
      end
   end

   // Pin drive registered: decode change shows one edge later
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pin_out <= 8'h00;
         pin_oe  <= 8'h00;
      end else begin
         pin_out <= pin_out_nxt;
         pin_oe  <= pin_oe_nxt;
      end
   end

   // Peripheral inputs see sampled levels regardless of function; capture and trigger enables are decoded
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         timer_a_signal_in  <= 1'b0;
         timer_b_signal_in  <= 1'b0;
         timer_a_capture_en <= 1'b0;
         timer_b_capture_en <= 1'b0;
         adc_ext_trigger    <= 1'b0;
         adc_ext_trigger_en <= 1'b0;
         serial3_rx_pin     <= 1'b0;
         serial4_rx_pin     <= 1'b0;
         twowire0_data_pin  <= 1'b0;
         twowire0_clk_pin   <= 1'b0;
         twowire1_data_pin  <= 1'b0;
         twowire1_clk_pin   <= 1'b0;
      end else begin
         timer_a_signal_in  <= pin_s[6];
         timer_b_signal_in  <= pin_s[7];
         timer_a_capture_en <= a_cap;
         timer_b_capture_en <= b_cap;
         adc_ext_trigger    <= pin_s[7];
         adc_ext_trigger_en <= trig_sel;
         serial3_rx_pin     <= pin_s[1];
         serial4_rx_pin     <= pin_s[3];
         twowire0_data_pin  <= pin_s[1];
         twowire0_clk_pin   <= pin_s[0];
         twowire1_data_pin  <= pin_s[3];
         twowire1_clk_pin   <= pin_s[2];
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_readback_mix: assert property (
      (hsel && htrans[1] && hready && !hwrite &&
       haddr[7:0] == `P8MUX_OFF_READBACK) |=>
         (hrdata[7:0] == ((direction_bits & output_latch) |
                          (~direction_bits & pin_s))))
      else $error("readback does not mix latch and pin");
   a_readback_ro: assert property (
      (hsel && htrans[1] && hready && hwrite &&
       haddr[7:0] == `P8MUX_OFF_READBACK) |=> ##1
         ($stable(direction_bits) && $stable(output_latch) &&
          $stable(timer_pin_route_ctrl)))
      else $error("write to readback changed a register");
   a_route_off_gpio: assert property (
      (!route_b && !trig_sel) |=> (pin_out[7] == $past(output_latch[7]) &&
                      pin_oe[7] == $past(direction_bits[7])))
      else $error("pin 7 not gpio with route clear");
   a_timer_b_drive: assert property (
      (route_b && mode_nrm && io_is_compare(timer_b_io_ctrl)) |=>
         (pin_oe[7] && pin_out[7] == $past(timer_b_signal_out)))
      else $error("pin 7 does not drive timer B compare");
   a_timer_b_cap: assert property (
      (route_b && mode_nrm && timer_b_io_ctrl[3:2] == 2'b10) |=>
         timer_b_capture_en)
      else $error("timer B capture not enabled");
   a_adc_trigger: assert property (
      (adc_trig_src_hi && adc_trig_src_lo) |=>
         (adc_ext_trigger_en && adc_ext_trigger == $past(pin_s[7])))
      else $error("adc trigger not fed from pin 7");
   a_timer_a_pwm1: assert property (
      (route_a && mode_pw1 && timer_a_io_ctrl[1:0] != 2'b00) |=>
         (pin_oe[6] && pin_out[6] == $past(timer_a_signal_out)))
      else $error("pin 6 does not drive timer A pwm1");
   a_timer_a_cap: assert property (
      (route_a && mode_nrm && timer_a_io_ctrl[3:2] == 2'b10) |=>
         timer_a_capture_en)
      else $error("timer A capture not enabled");
   a_pwm1_blocks_b: assert property (
      a_pwm1_on_pin |=> (pin_oe[7] == $past(direction_bits[7]) &&
                         pin_out[7] == $past(output_latch[7])))
      else $error("timer B drives during pwm mode 1");
   a_pwm_wave1: assert property (
      pwm_out_enable_b |=> (pin_oe[5] && pin_out[5] == $past(pwm_wave_out1)))
      else $error("pin 5 not pwm wave 1");
   a_pwm_wave0: assert property (
      pwm_out_enable_a |=> (pin_oe[4] && pin_out[4] == $past(pwm_wave_out0)))
      else $error("pin 4 not pwm wave 0");
   a_serial_rx_in: assert property (
      (!twowire0_enable && serial3_rx_enable) |=> !pin_oe[1])
      else $error("pin 1 driven while serial receive");
   a_serial_tx_pp: assert property (
      (!twowire0_enable && serial3_tx_enable) |=>
         (pin_oe[0] && pin_out[0] == $past(serial3_tx_pin)))
      else $error("pin 0 not push-pull transmit");
   a_twowire_od: assert property (
      twowire1_enable |=>
         (!pin_out[3] && pin_oe[3] == !$past(twowire1_data_drv)))
      else $error("two-wire data not open drain");
   a_gpio_dir: assert property (
      (!pwm_out_enable_a) |=>
         (pin_oe[4] == $past(direction_bits[4]) &&
          pin_out[4] == $past(output_latch[4])))
      else $error("pin 4 gpio not following direction");
   a_sampled_in: assert property (
      ##2 (timer_a_signal_in == $past(pin_in[6], 3)))
      else $error("timer A input not the sampled pin");

   c_timer_b_out: cover property (b_drive ##1 pin_oe[7]);
   c_timer_a_pwm1: cover property (a_pwm1_on_pin ##1 pin_oe[6]);
   c_twowire_low: cover property (twowire0_enable && !twowire0_clk_drv);
   c_readback_rd: cover property (
      hsel && htrans[1] && hready && !hwrite &&
      haddr[7:0] == `P8MUX_OFF_READBACK);
endmodule : p8mux_top
`default_nettype wire

// file: shared/p8mux_defines.svh
// Offsets, field positions, reset values and decode codes of the port mux.
// Assumes inclusion by bare name from the top and register design files.
`ifndef P8MUX_DEFINES_SVH
`define P8MUX_DEFINES_SVH

`define P8MUX_OFF_DIRECTION   8'h00
`define P8MUX_OFF_LATCH       8'h04
`define P8MUX_OFF_READBACK    8'h08
`define P8MUX_OFF_ROUTE       8'h0c
`define P8MUX_ADDR_W          8

`define P8MUX_RST_DIRECTION   8'h00
`define P8MUX_RST_LATCH       8'h00
`define P8MUX_RST_ROUTE       2'h0

`define P8MUX_ROUTE_A_BIT     0
`define P8MUX_ROUTE_B_BIT     1
`define P8MUX_ROUTE_W         2

`define P8MUX_MODE_NORMAL     4'h0
`define P8MUX_MODE_PWM1       4'h2
`define P8MUX_MODE_PWM2       4'h3
`define P8MUX_CCLR_A_NOPWM2   3'h1
`define P8MUX_CCLR_B_NOPWM2   3'h2

`endif

// file: shared/p8mux_pkg.sv
// Types shared by the port mux design files.
// Includes no header and uses none of the defines.
`default_nettype none
package p8mux_pkg;
   typedef enum logic [1:0] {
      P8MUX_FN_GPIO,
      P8MUX_FN_SERIAL,
      P8MUX_FN_TWOWIRE
   } p8mux_low_fn_t;
endpackage : p8mux_pkg
`default_nettype wire

// file: logic/p8mux_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes a single clock and synchronous active-low reset.
`default_nettype none
module p8mux_sync #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : p8mux_sync
`default_nettype wire

// file: logic/p8mux_ahb_regs.sv
// AHB-Lite slave holding direction, latch and route registers.
// Assumes single word transfers; readback value is supplied by the parent.
`default_nettype none
`include "p8mux_defines.svh"
module p8mux_ahb_regs (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [7:0]  readback,
   output var  logic [7:0]  direction_bits,
   output var  logic [7:0]  output_latch,
   output var  logic [1:0]  timer_pin_route_ctrl
);
   logic       wr_pend_r;
   logic [7:0] addr_r;
   logic       accept;
   logic       is_dir;
   logic       is_lat;
   logic       is_rte;
   logic       is_rbk;

   assign accept    = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign is_dir    = addr_r == `P8MUX_OFF_DIRECTION;
   assign is_lat    = addr_r == `P8MUX_OFF_LATCH;
   assign is_rte    = addr_r == `P8MUX_OFF_ROUTE;
   assign is_rbk    = addr_r == `P8MUX_OFF_READBACK;

   // Read mux on the data-phase address; unmapped reads return zero
   assign hrdata = is_dir ? {24'h000000, direction_bits} :
                   is_lat ? {24'h000000, output_latch} :
                   is_rbk ? {24'h000000, readback} :
                   is_rte ? {30'h0, timer_pin_route_ctrl} :
                   32'h00000000;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= accept && hwrite;
         addr_r    <= accept ? {haddr[7:2], 2'b00} : 8'h00;
      end
   end

   // Readback offset has no storage, so writes to it fall through
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         direction_bits       <= `P8MUX_RST_DIRECTION;
         output_latch         <= `P8MUX_RST_LATCH;
         timer_pin_route_ctrl <= `P8MUX_RST_ROUTE;
      end else if (wr_pend_r) begin
         if (is_dir) begin
            direction_bits <= hwdata[7:0];
         end else if (is_lat) begin
            output_latch <= hwdata[7:0];
         end else if (is_rte) begin
            timer_pin_route_ctrl <= hwdata[1:0];
         end
      end
   end
endmodule : p8mux_ahb_regs
`default_nettype wire

// file: verif/p8mux_board.sv
// Board model: resolves each port pin from the device drive and outside level.
// Assumes outside parties drive a pin only while the device releases it.
`default_nettype none
module p8mux_board (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_lvl,
   output logic [7:0]      pin_lvl
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released lines follow the outside party, which changes every test
   assign pin_lvl = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : p8mux_board
`default_nettype wire

// file: verif/test_pin_level_readback_pin_function_mux.sv
// Self-checking bench for the port 8 pin mux: random setups against a model.
// Assumes the board model resolves pins; AHB-Lite master with one slave.
`default_nettype none
module test_pin_level_readback_pin_function_mux;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  pin_in, pin_out, pin_oe, ext_lvl, m_dir, m_latch, m_route;
   logic [3:0]  timer_mode_field, timer_a_io_ctrl, timer_b_io_ctrl;
   logic [2:0]  counter_clear_sel;
   logic timer_a_signal_out, timer_b_signal_out, timer_a_signal_in;
   logic timer_b_signal_in, timer_a_capture_en, timer_b_capture_en;
   logic adc_trig_src_hi, adc_trig_src_lo, adc_ext_trigger, adc_ext_trigger_en;
   logic pwm_out_enable_a, pwm_out_enable_b, pwm_wave_out0, pwm_wave_out1;
   logic serial3_rx_enable, serial3_tx_enable, serial3_tx_pin, serial3_rx_pin;
   logic serial4_rx_enable, serial4_tx_enable, serial4_tx_pin, serial4_rx_pin;
   logic twowire0_enable, twowire0_data_drv, twowire0_clk_drv;
   logic twowire0_data_pin, twowire0_clk_pin, twowire1_enable;
   logic twowire1_data_drv, twowire1_clk_drv, twowire1_data_pin;
   logic twowire1_clk_pin;
   wire  hready = hreadyout;
   int   n_mismatch, checks_done, cycles;

   p8mux_top uut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pin_in, .pin_out,
      .pin_oe, .timer_mode_field, .timer_a_io_ctrl, .timer_b_io_ctrl,
      .counter_clear_sel, .timer_a_signal_out, .timer_b_signal_out,
      .timer_a_signal_in, .timer_b_signal_in, .timer_a_capture_en,
      .timer_b_capture_en, .adc_trig_src_hi, .adc_trig_src_lo,
      .adc_ext_trigger, .adc_ext_trigger_en, .pwm_out_enable_a,
      .pwm_out_enable_b, .pwm_wave_out0, .pwm_wave_out1, .serial3_rx_enable,
      .serial3_tx_enable, .serial3_tx_pin, .serial3_rx_pin,
      .serial4_rx_enable, .serial4_tx_enable, .serial4_tx_pin,
      .serial4_rx_pin, .twowire0_enable, .twowire0_data_drv,
      .twowire0_clk_drv, .twowire0_data_pin, .twowire0_clk_pin,
      .twowire1_enable, .twowire1_data_drv, .twowire1_clk_drv,
      .twowire1_data_pin, .twowire1_clk_pin);
   p8mux_board board (.pin_out, .pin_oe, .ext_lvl, .pin_lvl(pin_in));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One single transfer; levels are taken just before the sampling edge
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
      logic ok;
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(negedge core_clk);
         ok = hready;
         @(posedge core_clk);
      end while (ok !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(negedge core_clk);
         ok = hready;
         rd = hrdata;
         chk("response", hresp, 32'h0);
         @(posedge core_clk);
      end while (ok !== 1'b1);
   endtask : xfer

   task automatic drive(input logic [42:0] v);
      {timer_mode_field, timer_a_io_ctrl, timer_b_io_ctrl, counter_clear_sel,
       timer_a_signal_out, timer_b_signal_out, adc_trig_src_hi,
       adc_trig_src_lo, pwm_out_enable_a, pwm_out_enable_b, pwm_wave_out0,
       pwm_wave_out1, serial3_rx_enable, serial3_tx_enable, serial3_tx_pin,
       serial4_rx_enable, serial4_tx_enable, serial4_tx_pin, twowire0_enable,
       twowire0_data_drv, twowire0_clk_drv, twowire1_enable,
       twowire1_data_drv, twowire1_clk_drv, ext_lvl} <= v;
   endtask : drive

   function automatic void model(output logic [7:0] oe, output logic [7:0] ov);
      logic [3:0] md;
      logic       aa, ba, a_on, b_on;
      md = timer_mode_field;
      aa = timer_a_io_ctrl[1:0] != 2'b00;
      ba = timer_b_io_ctrl[1:0] != 2'b00;
      a_on = m_route[0] && ((md == 4'h0 && !timer_a_io_ctrl[3] && aa) ||
             (md == 4'h2 && aa) ||
             (md == 4'h3 && aa && counter_clear_sel != 3'h1));
      b_on = m_route[1] && ((md == 4'h0 && !timer_b_io_ctrl[3] && ba) ||
             (md == 4'h3 && ba && counter_clear_sel != 3'h2)) &&
             !(m_route[0] && md == 4'h2 && aa);
      oe = m_dir;
      ov = m_latch;
      if (b_on) {oe[7], ov[7]} = {1'b1, timer_b_signal_out};
      if (a_on) {oe[6], ov[6]} = {1'b1, timer_a_signal_out};
      if (pwm_out_enable_b) {oe[5], ov[5]} = {1'b1, pwm_wave_out1};
      if (pwm_out_enable_a) {oe[4], ov[4]} = {1'b1, pwm_wave_out0};
      if (twowire1_enable) begin
         {oe[3], ov[3]} = {!twowire1_data_drv, 1'b0};
         {oe[2], ov[2]} = {!twowire1_clk_drv, 1'b0};
      end else begin
         if (serial4_rx_enable) oe[3] = 1'b0;
         if (serial4_tx_enable) {oe[2], ov[2]} = {1'b1, serial4_tx_pin};
      end
      if (twowire0_enable) begin
         {oe[1], ov[1]} = {!twowire0_data_drv, 1'b0};
         {oe[0], ov[0]} = {!twowire0_clk_drv, 1'b0};
      end else begin
         if (serial3_rx_enable) oe[1] = 1'b0;
         if (serial3_tx_enable) {oe[0], ov[0]} = {1'b1, serial3_tx_pin};
      end
   endfunction : model

   initial begin : main
      logic [63:0] rv;
      logic [31:0] r, v;
      logic [7:0]  eoe, eov, lv;
      logic        ca, cb;
      {rst_n, hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
      drive('0);
      void'($urandom(32'hf6c9));
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk("reset oe", pin_oe, 32'h0);
      @(posedge core_clk);
      xfer(1'b0, 8'h00, 32'h0, v);
      chk("reset direction", v, 32'h0);
      xfer(1'b0, 8'h04, 32'h0, v);
      chk("reset latch", v, 32'h0);
      xfer(1'b0, 8'h0c, 32'h0, v);
      chk("reset route", v, 32'h0);
      xfer(1'b1, 8'h10, 32'hff, v);
      xfer(1'b0, 8'h10, 32'h0, v);
      chk("unmapped", v, 32'h0);
      $display("reset and map test done");
      for (int k = 0; k < 100; k++) begin
         rv = {$urandom, $urandom};
         r = $urandom;
         if (r[18]) rv[42:41] = 2'b00;
         {m_route, m_latch, m_dir} = {6'h0, r[17:0]};
         xfer(1'b1, 8'h00, {24'h0, m_dir}, v);
         xfer(1'b1, 8'h04, {24'h0, m_latch}, v);
         xfer(1'b1, 8'h0c, {24'h0, m_route}, v);
         drive(rv[42:0]);
         @(posedge core_clk);
         @(negedge core_clk);
         model(eoe, eov);
         lv = (eov & eoe) | (ext_lvl & ~eoe);
         chk("pin oe", pin_oe, eoe);
         chk("pin out", pin_out & pin_oe,
             eov & eoe);
         chk("pin 4 5", {pin_oe[5:4], pin_out[5:4]},
             {eoe[5:4], eov[5:4]});
         chk("push pull", pin_oe & ~eov & ~m_dir,
             eoe & ~eov & ~m_dir);
         repeat (4) @(posedge core_clk);
         @(negedge core_clk);
         ca = m_route[0] && timer_mode_field == 4'h0 &&
              timer_a_io_ctrl[3:2] == 2'b10;
         cb = m_route[1] && timer_mode_field == 4'h0 &&
              timer_b_io_ctrl[3:2] == 2'b10;
         chk("capture", {timer_a_capture_en, timer_b_capture_en},
             {ca, cb});
         chk("trigger", {adc_ext_trigger_en, adc_ext_trigger},
             {adc_trig_src_hi & adc_trig_src_lo, lv[7]});
         chk("inputs", {timer_a_signal_in, timer_b_signal_in, serial3_rx_pin,
             serial4_rx_pin, twowire0_data_pin, twowire0_clk_pin,
             twowire1_data_pin, twowire1_clk_pin},
             {lv[6], lv[7], lv[1], lv[3], lv[1:0], lv[3:2]});
         @(posedge core_clk);
         xfer(1'b0, 8'h08, 32'h0, v);
         chk("readback", v,
             {24'h0, (m_dir & m_latch) | (~m_dir & lv)});
         xfer(1'b1, 8'h08, ~v, v);
         xfer(1'b0, 8'h00, 32'h0, v);
         chk("direction kept", v, {24'h0, m_dir});
         xfer(1'b0, 8'h04, 32'h0, v);
         chk("latch kept", v, {24'h0, m_latch});
         xfer(1'b0, 8'h0c, 32'h0, v);
         chk("route kept", v, {24'h0, m_route});
         @(negedge core_clk);
         chk("pins kept", {pin_oe, pin_out & pin_oe},
             {eoe, eov & eoe});
         @(posedge core_clk);
         $display("random setup %0d done", k);
      end
      complete_run();
   end
endmodule : test_pin_level_readback_pin_function_mux
`default_nettype wire
